// [debug_unit_pkg.sv]
// Purpose: constants for the breakpoint and debug exception unit
// Assumes: 32-bit linear addresses, four breakpoints
// Notes:   register indices are the debug register numbers
//
// Overview of operation
// - four address registers, fields from control
// - enabled breakpoint hit raises debug exception
// - type: 00 exec, 01 write, 11 read/write
// - length: 00 one, 01 two, 11 four bytes
// - execution break taken before instruction runs
// - global enables survive task switches
// - local enables cleared on task switch
// - lock bit blocks access, cleared on exception
// - hit flags set even when not enabled, but only in a cycle that raises a debug exception
// - task switch trap flag set for trapped task
// - single step flag set for step trap
// - status never cleared by hardware itself
// - trap flag gives exception every instruction
// - register moves only at privilege level zero or in real mode
`default_nettype none

package debug_unit_pkg;

    localparam int          NUM_BP          = 4;

    // move-instruction register indices
    localparam logic [2:0]  REG_BP0         = 3'h0;
    localparam logic [2:0]  REG_BP3         = 3'h3;
    localparam logic [2:0]  REG_STATUS      = 3'h6;
    localparam logic [2:0]  REG_CONTROL     = 3'h7;

    // control layout
    localparam int          CTRL_GD_BIT     = 13;
    localparam int          CTRL_FIELD_LSB  = 16;
    localparam int          CTRL_FIELD_W    = 4;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0400;
    localparam logic [31:0] CTRL_WMASK      = 32'hFFFF_20FF;

    // status layout
    localparam int          STAT_BS_BIT     = 14;
    localparam int          STAT_BT_BIT     = 15;
    localparam logic [31:0] STAT_RESET      = 32'h0000_0000;
    localparam logic [31:0] STAT_WMASK      = 32'h0000_C00F;

    localparam int          FLAGS_TF_BIT    = 8;

    localparam logic [1:0]  TYPE_EXEC       = 2'h0;
    localparam logic [1:0]  TYPE_WRITE      = 2'h1;
    localparam logic [1:0]  TYPE_RW         = 2'h3;

    localparam logic [1:0]  LEN_ONE         = 2'h0;
    localparam logic [1:0]  LEN_TWO         = 2'h1;
    localparam logic [1:0]  LEN_FOUR        = 2'h3;

endpackage

`default_nettype wire

// [bp_compare.sv]
// Purpose: address, type and length match for one breakpoint
// Assumes: accesses do not cross an aligned dword
// Notes:   conditions are raw; enables are applied by the caller
`timescale 1ns/1ps
`default_nettype none

module bp_compare (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] bp_addr,
    input  wire logic [1:0]  access_type_field,
    input  wire logic [1:0]  match_length_field,
    input  wire logic [31:0] fetch_addr,
    input  wire logic [31:0] data_addr,
    input  wire logic [1:0]  data_size,
    input  wire logic        data_write,
    output logic             exec_cond,
    output logic             data_cond
);
    import debug_unit_pkg::*;

    // byte lanes of an aligned span; unused code 10 covers nothing
    function automatic logic [3:0] span_mask(
        input logic [1:0] lo,
        input logic [1:0] len
    );
        logic [3:0] m;
        m = 4'h0;
        unique case (len)
            LEN_ONE:  m = 4'h1 << lo;
            LEN_TWO:  m = 4'h3 << {lo[1], 1'b0};
            LEN_FOUR: m = 4'hF;
            default:  m = 4'h0;
        endcase
        return m;
    endfunction

    logic [3:0] bp_mask;
    logic       fetch_same;
    logic       data_same;
    logic       type_ok;

    assign bp_mask    = span_mask(bp_addr[1:0], match_length_field);
    assign fetch_same = fetch_addr[31:2] == bp_addr[31:2];
    assign data_same  = data_addr[31:2] == bp_addr[31:2];

    assign type_ok = (access_type_field == TYPE_RW)
        || (access_type_field == TYPE_WRITE && data_write);

    assign exec_cond = access_type_field == TYPE_EXEC && fetch_same
        && |(bp_mask & span_mask(fetch_addr[1:0], LEN_ONE));
    assign data_cond = type_ok && data_same
        && |(bp_mask & span_mask(data_addr[1:0], data_size));

    a_unused_type: assert property (
        @(posedge clk) disable iff (!rst_b)
        access_type_field == 2'h2 |-> !exec_cond && !data_cond)
        else $error("unused type code produced a match");

    a_four_span: assert property (
        @(posedge clk) disable iff (!rst_b)
        match_length_field == LEN_FOUR && access_type_field == TYPE_RW
        && data_same && data_size != 2'h2 |-> data_cond)
        else $error("four-byte span missed an access");

endmodule

`default_nettype wire

// [breakpoint_debug_unit.sv]
// Purpose: breakpoint registers and debug exception logic
// Assumes: core stalls fetch the cycle debug_exception is high
// Notes:   move accesses are answered one cycle after they issue
`timescale 1ns/1ps
`default_nettype none

module breakpoint_debug_unit (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        data_valid,
    input  wire logic        data_write,
    input  wire logic [31:0] data_addr,
    input  wire logic [1:0]  data_size,
    input  wire logic        retire_valid,
    input  wire logic [31:0] processor_flags_register,
    input  wire logic        task_switch,
    input  wire logic        task_trap_bit,
    input  wire logic        mov_valid,
    input  wire logic        mov_write,
    input  wire logic [2:0]  mov_index,
    input  wire logic [31:0] mov_wdata,
    input  wire logic [1:0]  mov_priv_level,
    input  wire logic        real_mode,
    output logic             debug_exception,
    output logic             mov_done,
    output logic             mov_priv_fault,
    output logic [31:0]      mov_rdata,
    output logic [31:0]      debug_control,
    output logic [31:0]      debug_status
);
    import debug_unit_pkg::*;

    typedef struct packed {
        logic [NUM_BP-1:0][31:0] bp_addr;
        logic [31:0]             control;
        logic [31:0]             status;
        logic [31:0]             rdata;
        logic                    done;
        logic                    priv_fault;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic [NUM_BP-1:0] exec_cond;
    logic [NUM_BP-1:0] data_cond;
    logic [NUM_BP-1:0] bp_enabled;
    logic [NUM_BP-1:0] local_enable_bit;
    logic [NUM_BP-1:0] global_enable_bit;
    logic [NUM_BP-1:0] hit_cond;
    logic              exec_hit;
    logic              data_hit;
    logic              trap_flag;
    logic              step_trap;
    logic              tss_trap;
    logic              priv_ok;
    logic              debug_access_lock;
    logic              lock_trap;
    logic              mov_go;
    logic              mov_store;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BP; gi++)
        begin : g_bp
            localparam int FLSB = CTRL_FIELD_LSB + gi * CTRL_FIELD_W;

            assign local_enable_bit[gi]  = state_q.control[2 * gi];
            assign global_enable_bit[gi] = state_q.control[2 * gi + 1];
            assign bp_enabled[gi] = local_enable_bit[gi]
                | global_enable_bit[gi];

            bp_compare u_cmp (
                .clk                (clk),
                .rst_b              (rst_b),
                .bp_addr            (state_q.bp_addr[gi]),
                .access_type_field  (state_q.control[FLSB +: 2]),
                .match_length_field (state_q.control[FLSB + 2 +: 2]),
                .fetch_addr         (fetch_addr),
                .data_addr          (data_addr),
                .data_size          (data_size),
                .data_write         (data_write),
                .exec_cond          (exec_cond[gi]),
                .data_cond          (data_cond[gi])
            );
        end
    endgenerate

    // decode and field packing serve four breakpoints
    if (NUM_BP != 4)
    begin : g_bad_count
        $error("unsupported breakpoint count");
    end

    assign hit_cond = ({NUM_BP{fetch_valid}} & exec_cond)
        | ({NUM_BP{data_valid}} & data_cond);

    assign exec_hit = fetch_valid && |(exec_cond & bp_enabled);
    assign data_hit = data_valid && |(data_cond & bp_enabled);

    // single step after each retired instruction
    assign trap_flag = processor_flags_register[FLAGS_TF_BIT];
    assign step_trap = retire_valid && trap_flag;
    assign tss_trap  = task_switch && task_trap_bit;

    // moves allowed only at level zero or in real mode
    assign priv_ok = real_mode || mov_priv_level == 2'h0;

    // lock turns any move allowed by privilege into an exception
    assign debug_access_lock = state_q.control[CTRL_GD_BIT];
    assign lock_trap = mov_valid && priv_ok && debug_access_lock;
    assign mov_go    = mov_valid && priv_ok && !debug_access_lock;
    assign mov_store = mov_go && mov_write;

    // combinational so the fetch is squashed
    assign debug_exception = exec_hit || data_hit || step_trap
        || tss_trap || lock_trap;

    function automatic logic [31:0] read_reg(
        input state_s     s,
        input logic [2:0] idx
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx <= REG_BP3)
        begin
            v = s.bp_addr[idx[1:0]];
        end
        else if (idx == REG_STATUS)
        begin
            v = s.status;
        end
        else if (idx == REG_CONTROL)
        begin
            v = s.control;
        end
        return v;
    endfunction

    always_comb
    begin
        state_d            = state_q;
        state_d.done       = mov_valid;
        state_d.priv_fault = mov_valid && !priv_ok;
        state_d.rdata      = 32'h0000_0000;

        if (mov_go && !mov_write)
        begin
            state_d.rdata = read_reg(state_q, mov_index);
        end

        if (mov_store && mov_index <= REG_BP3)
        begin
            state_d.bp_addr[mov_index[1:0]] = mov_wdata;
        end

        if (mov_store && mov_index == REG_CONTROL)
        begin
            state_d.control = (mov_wdata & CTRL_WMASK)
                | (CTRL_RESET & ~CTRL_WMASK);
        end

        if (mov_store && mov_index == REG_STATUS)
        begin
            state_d.status = mov_wdata & STAT_WMASK;
        end

        // local enables dropped on task switch
        if (task_switch)
        begin
            for (int i = 0; i < NUM_BP; i++)
            begin
                state_d.control[2 * i] = 1'b0;
            end
        end

        if (debug_exception)
        begin
            state_d.status[NUM_BP-1:0] = state_d.status[NUM_BP-1:0]
                | hit_cond;
            if (step_trap)
            begin
                state_d.status[STAT_BS_BIT] = 1'b1;
            end
            if (tss_trap)
            begin
                state_d.status[STAT_BT_BIT] = 1'b1;
            end
            state_d.control[CTRL_GD_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q.bp_addr    <= '0;
            state_q.control    <= CTRL_RESET;
            state_q.status     <= STAT_RESET;
            state_q.rdata      <= 32'h0000_0000;
            state_q.done       <= 1'b0;
            state_q.priv_fault <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign mov_done       = state_q.done;
    assign mov_priv_fault = state_q.priv_fault;
    assign mov_rdata      = state_q.rdata;
    assign debug_control  = state_q.control;
    assign debug_status   = state_q.status;

    // break in the fetch cycle itself
    a_exec_before: assert property (
        @(posedge clk) disable iff (!rst_b)
        fetch_valid && |(exec_cond & bp_enabled) |-> debug_exception)
        else $error("execution break not raised in fetch cycle");

    a_data_hit: assert property (
        @(posedge clk) disable iff (!rst_b)
        data_valid && |(data_cond & bp_enabled)
        |-> debug_exception ##1 |(debug_status[NUM_BP-1:0]))
        else $error("data breakpoint hit lost");

    a_lock_clear: assert property (
        @(posedge clk) disable iff (!rst_b)
        debug_exception |=> !debug_control[CTRL_GD_BIT])
        else $error("access lock survived a debug exception");

    // locked move changes no control bit but the lock
    a_lock_write: assert property (
        @(posedge clk) disable iff (!rst_b)
        mov_valid && mov_write && priv_ok && debug_access_lock
        && !task_switch |=> debug_control
        == ($past(debug_control) & ~(32'h1 << CTRL_GD_BIT)))
        else $error("locked move altered the control register");

    // local enables cleared by task switch
    a_local_clear: assert property (
        @(posedge clk) disable iff (!rst_b)
        task_switch |=> (debug_control[7:0] & 8'h55) == 8'h00)
        else $error("local enable kept across task switch");

    // global enables kept by task switch
    a_global_keep: assert property (
        @(posedge clk) disable iff (!rst_b)
        task_switch && !mov_store
        |=> (debug_control[7:0] & 8'hAA)
        == ($past(debug_control[7:0]) & 8'hAA))
        else $error("global enable changed by task switch");

    a_raw_hit: assert property (
        @(posedge clk) disable iff (!rst_b)
        debug_exception |=> (debug_status[NUM_BP-1:0]
        & $past(hit_cond)) == $past(hit_cond))
        else $error("met condition not recorded in status");

    a_step_flag: assert property (
        @(posedge clk) disable iff (!rst_b)
        retire_valid && trap_flag
        |-> debug_exception ##1 debug_status[STAT_BS_BIT])
        else $error("single step trap not flagged");

    a_tss_flag: assert property (
        @(posedge clk) disable iff (!rst_b)
        task_switch && task_trap_bit
        |-> debug_exception ##1 debug_status[STAT_BT_BIT])
        else $error("task switch trap not flagged");

    // status bits only fall by software write
    a_status_sticky: assert property (
        @(posedge clk) disable iff (!rst_b)
        !(mov_store && mov_index == REG_STATUS)
        |=> (debug_status & $past(debug_status)) == $past(debug_status))
        else $error("status bit cleared by hardware");

    a_priv_refuse: assert property (
        @(posedge clk) disable iff (!rst_b)
        mov_valid && !real_mode && mov_priv_level != 2'h0
        |=> mov_done && mov_priv_fault && mov_rdata == 32'h0000_0000)
        else $error("move accepted above level zero");

    // address register write and read back
    a_addr_store: assert property (
        @(posedge clk) disable iff (!rst_b)
        mov_store && mov_index == REG_BP0
        ##1 mov_go && !mov_write && mov_index == REG_BP0
        |=> mov_rdata == $past(mov_wdata, 2))
        else $error("breakpoint address not stored");

    a_move_answer: assert property (
        @(posedge clk) disable iff (!rst_b)
        mov_valid |=> mov_done && mov_priv_fault != $past(priv_ok))
        else $error("move not answered in the next cycle");

    a_no_answer: assert property (
        @(posedge clk) disable iff (!rst_b)
        !mov_valid
        |=> !mov_done && !mov_priv_fault && mov_rdata == 32'h0000_0000)
        else $error("move answer without a move");

    a_lock_read: assert property (
        @(posedge clk) disable iff (!rst_b)
        lock_trap |-> debug_exception
        ##1 !mov_priv_fault && mov_rdata == 32'h0000_0000)
        else $error("locked move returned data");

    a_idle_quiet: assert property (
        @(posedge clk) disable iff (!rst_b)
        !fetch_valid && !data_valid && !retire_valid && !task_switch
        && !mov_valid |-> !debug_exception)
        else $error("debug exception without a cause");

    // status moves only on exception or store
    a_status_hold: assert property (
        @(posedge clk) disable iff (!rst_b)
        !debug_exception && !(mov_store && mov_index == REG_STATUS)
        |=> $stable(debug_status))
        else $error("status changed without a cause");

    a_fixed_bits: assert property (
        @(posedge clk) disable iff (!rst_b)
        (debug_control & ~CTRL_WMASK) == (CTRL_RESET & ~CTRL_WMASK)
        && (debug_status & ~STAT_WMASK) == 32'h0000_0000)
        else $error("reserved register bit changed");

endmodule

`default_nettype wire

// [core_pipeline_model.sv]
// Purpose: core pipeline stand-in issuing fetch, data and step events
// Assumes: one event per request, launched one cycle after the request
// Notes:   idle address and qualifier lines toggle so stale values never
//          pass for a live access
`timescale 1ns/1ps
`default_nettype none

module core_pipeline_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_kind,
    input  wire logic [31:0] req_addr,
    input  wire logic [1:0]  req_size,
    input  wire logic        req_write,
    input  wire logic        req_flag,
    output logic             fetch_valid,
    output logic [31:0]      fetch_addr,
    output logic             data_valid,
    output logic             data_write,
    output logic [31:0]      data_addr,
    output logic [1:0]       data_size,
    output logic             retire_valid,
    output logic [31:0]      processor_flags_register,
    output logic             task_switch,
    output logic             task_trap_bit
);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fetch_valid <= 1'b0;
            fetch_addr <= 32'h0000_0000;
            data_valid <= 1'b0;
            data_write <= 1'b0;
            data_addr <= 32'h0000_0000;
            data_size <= 2'h0;
            retire_valid <= 1'b0;
            processor_flags_register <= 32'h0000_0002;
            task_switch <= 1'b0;
            task_trap_bit <= 1'b0;
        end
        else
        begin
            fetch_valid <= req_valid && req_kind == 2'h0;
            data_valid <= req_valid && req_kind == 2'h1;
            retire_valid <= req_valid && req_kind == 2'h2;
            task_switch <= req_valid && req_kind == 2'h3;
            fetch_addr <= req_valid ? req_addr : ~fetch_addr;
            data_addr <= req_valid ? req_addr : ~data_addr;
            data_write <= req_valid ? req_write : ~data_write;
            data_size <= req_valid ? req_size : ~data_size;
            task_trap_bit <= req_valid ? req_flag : ~task_trap_bit;
            if (req_valid)
                processor_flags_register <= {23'h0, req_flag, 8'h02};
        end
    end

endmodule

`default_nettype wire

// [breakpoint_debug_unit_bench.sv]
// Purpose: self-checking bench for the breakpoint debug unit
// Assumes: move answers one cycle late, exception is combinational
// Notes:   reference model keeps control, status and addresses in vars
`timescale 1ns/1ps
`default_nettype none

module breakpoint_debug_unit_bench;
    import debug_unit_pkg::*;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req_valid = 1'b0;
    logic [1:0]  req_kind = 2'h0;
    logic [31:0] req_addr = 32'h0000_0000;
    logic [1:0]  req_size = 2'h0;
    logic        req_write = 1'b0;
    logic        req_flag = 1'b0;
    logic        mov_valid = 1'b0;
    logic        mov_write = 1'b0;
    logic [2:0]  mov_index = 3'h0;
    logic [31:0] mov_wdata = 32'h0000_0000;
    logic [1:0]  mov_priv_level = 2'h0;
    logic        real_mode = 1'b0;
    logic        fetch_valid, data_valid, data_write, retire_valid;
    logic        task_switch, task_trap_bit, debug_exception;
    logic        mov_done, mov_priv_fault;
    logic [31:0] fetch_addr, data_addr, flags, mov_rdata;
    logic [31:0] debug_control, debug_status;
    logic [1:0]  data_size;
    logic [31:0] m_ctrl, m_stat, r;
    logic [31:0] m_bp [4];
    int          err_count = 0;
    int          comparisons = 0;
    int          i, n;
    integer      seed = 32'hc0a6;

    always #2 clk = ~clk;

    core_pipeline_model core (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
        .req_size(req_size), .req_write(req_write), .req_flag(req_flag),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .data_valid(data_valid), .data_write(data_write),
        .data_addr(data_addr), .data_size(data_size),
        .retire_valid(retire_valid), .processor_flags_register(flags),
        .task_switch(task_switch), .task_trap_bit(task_trap_bit));

    breakpoint_debug_unit dut (.clk(clk), .rst_b(rst_b),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .data_valid(data_valid), .data_write(data_write),
        .data_addr(data_addr), .data_size(data_size),
        .retire_valid(retire_valid), .processor_flags_register(flags),
        .task_switch(task_switch), .task_trap_bit(task_trap_bit),
        .mov_valid(mov_valid), .mov_write(mov_write),
        .mov_index(mov_index), .mov_wdata(mov_wdata),
        .mov_priv_level(mov_priv_level), .real_mode(real_mode),
        .debug_exception(debug_exception), .mov_done(mov_done),
        .mov_priv_fault(mov_priv_fault), .mov_rdata(mov_rdata),
        .debug_control(debug_control), .debug_status(debug_status));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // byte lanes touched within the dword
    function automatic logic [3:0] lane(input logic [1:0] lo,
                                        input logic [1:0] ln);
        case (ln)
            2'h0: return 4'h1 << lo;
            2'h1: return 4'h3 << {lo[1], 1'b0};
            2'h3: return 4'hf;
            default: return 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] hits(input logic f, input logic wr,
                                        input logic [31:0] a,
                                        input logic [1:0] sz);
        logic [3:0] h;
        logic [1:0] ty;
        h = 4'h0;
        for (int k = 0; k < 4; k++)
        begin
            ty = m_ctrl[16 + 4 * k +: 2];
            if (m_bp[k][31:2] == a[31:2]
                && (lane(m_bp[k][1:0], m_ctrl[18 + 4 * k +: 2])
                    & lane(a[1:0], f ? 2'h0 : sz)) != 4'h0
                && (f ? ty == 2'h0 : (ty == 2'h3 || (ty == 2'h1 && wr))))
                h[k] = 1'b1;
        end
        return h;
    endfunction

    task automatic core_op(input logic [1:0] k, input logic [31:0] a,
                           input logic [1:0] sz, input logic wr,
                           input logic fl);
        logic [3:0] h;
        logic       ex;
        h = k[1] ? 4'h0 : hits(k == 2'h0, wr, a, sz);
        ex = |(h & {m_ctrl[7] | m_ctrl[6], m_ctrl[5] | m_ctrl[4],
                    m_ctrl[3] | m_ctrl[2], m_ctrl[1] | m_ctrl[0]});
        ex = ex || (k[1] && fl);
        @(posedge clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_addr <= a;
        req_size <= sz;
        req_write <= wr;
        req_flag <= fl;
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        check(32'(debug_exception), 32'(ex), "exception");
        if (ex)
        begin
            m_stat = m_stat | {16'h0, k == 2'h3 && fl, k == 2'h2 && fl,
                               10'h0, h};
            m_ctrl[13] = 1'b0;
        end
        if (k == 2'h3)
            m_ctrl = m_ctrl & 32'hffff_ffaa;
        @(negedge clk);
        check(debug_status, m_stat, "status");
        check(debug_control, m_ctrl, "control");
    endtask

    task automatic register_move_instruction(input logic wr, input logic [2:0] idx,
                       input logic [31:0] wd, input logic [1:0] pl,
                       input logic rm);
        logic        ok, lk, ex;
        logic [31:0] exp;
        ok = pl == 2'h0 || rm;
        lk = ok && m_ctrl[13];
        exp = 32'h0000_0000;
        if (ok && !lk && !wr)
            exp = !idx[2] ? m_bp[idx[1:0]] : idx == 3'h6 ? m_stat
                : idx == 3'h7 ? m_ctrl : 32'h0000_0000;
        @(posedge clk);
        mov_valid <= 1'b1;
        mov_write <= wr;
        mov_index <= idx;
        mov_wdata <= wd;
        mov_priv_level <= pl;
        real_mode <= rm;
        @(negedge clk);
        ex = debug_exception;
        @(posedge clk);
        mov_valid <= 1'b0;
        @(negedge clk);
        check(32'(ex), 32'(lk), "lock exception");
        check(32'(mov_done), 32'h1, "done");
        check(32'(mov_priv_fault), 32'(!ok), "fault");
        check(mov_rdata, exp, "read data");
        if (lk)
            m_ctrl[13] = 1'b0;
        else if (ok && wr && idx == 3'h6)
            m_stat = wd & STAT_WMASK;
        else if (ok && wr && idx == 3'h7)
            m_ctrl = (wd & CTRL_WMASK) | CTRL_RESET;
        else if (ok && wr && !idx[2])
            m_bp[idx[1:0]] = wd;
        check(debug_control, m_ctrl, "control");
        check(debug_status, m_stat, "status");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial
    begin
        m_ctrl = CTRL_RESET;
        m_stat = STAT_RESET;
        for (i = 0; i < 4; i++)
            m_bp[i] = 32'h0000_0000;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 8; i++)
            register_move_instruction(1'b0, 3'(i), 32'h0000_0000, 2'h0, 1'b0);
        $display("test reset done");
        // write then read in back to back cycles
        @(posedge clk);
        mov_valid <= 1'b1;
        mov_write <= 1'b1;
        mov_index <= 3'h0;
        mov_wdata <= 32'h0000_00aa;
        @(posedge clk);
        mov_write <= 1'b0;
        @(posedge clk);
        mov_valid <= 1'b0;
        @(negedge clk);
        check(mov_rdata, 32'h0000_00aa, "back to back read");
        m_bp[0] = 32'h0000_00aa;
        register_move_instruction(1'b1, 3'h0, 32'h1234_5678, 2'h3, 1'b0);
        register_move_instruction(1'b1, 3'h0, 32'h1234_5678, 2'h3, 1'b1);
        register_move_instruction(1'b0, 3'h0, 32'h0000_0000, 2'h1, 1'b0);
        register_move_instruction(1'b0, 3'h0, 32'h0000_0000, 2'h0, 1'b0);
        $display("test privilege done");
        register_move_instruction(1'b1, 3'h7, 32'h0000_2003, 2'h0, 1'b0);
        core_op(2'h0, 32'h1234_5678, 2'h0, 1'b0, 1'b0);
        register_move_instruction(1'b1, 3'h7, 32'h0000_2003, 2'h0, 1'b0);
        register_move_instruction(1'b0, 3'h7, 32'h0000_0000, 2'h0, 1'b0);
        register_move_instruction(1'b1, 3'h7, 32'h0000_2003, 2'h0, 1'b0);
        register_move_instruction(1'b1, 3'h7, 32'h0000_00ff, 2'h0, 1'b0);
        core_op(2'h2, 32'h0000_0000, 2'h0, 1'b0, 1'b1);
        core_op(2'h2, 32'h0000_0000, 2'h0, 1'b0, 1'b0);
        $display("test lock and step done");
        register_move_instruction(1'b1, 3'h7, 32'h0000_00ff, 2'h0, 1'b0);
        core_op(2'h3, 32'h0000_0000, 2'h0, 1'b0, 1'b0);
        register_move_instruction(1'b1, 3'h7, 32'h0000_00ff, 2'h0, 1'b0);
        core_op(2'h3, 32'h0000_0000, 2'h0, 1'b0, 1'b1);
        register_move_instruction(1'b1, 3'h6, 32'h0000_0000, 2'h0, 1'b0);
        $display("test task switch done");
        for (n = 0; n < 320; n++)
        begin
            if (n % 16 == 0)
            begin
                register_move_instruction(1'b1, 3'h7, $random(seed) & 32'hffff_dfff, 2'h0, 1'b0);
                for (i = 0; i < 4; i++)
                    register_move_instruction(1'b1, 3'(i), 32'h1000_0000 | ($random(seed) & 7),
                        2'h0, 1'b0);
                register_move_instruction(1'b1, 3'h6, 32'h0000_0000, 2'h0, 1'b0);
            end
            r = $random(seed);
            r[4] = r[4] & !r[2];
            r[5] = r[5] & !(r[3] && r[2]);
            core_op(r[1:0], 32'h1000_0000 | r[6:4], r[3:2], r[7],
                    r[8]);
        end
        $display("test random traffic done");
        print_verdict();
    end

endmodule

`default_nettype wire
